// file: acjae_pkg.sv
package acjae_pkg;
    // Opcode patterns and masks
    localparam logic [7:0] OP_PAGE_MASK   = 8'h1f;
    localparam logic [4:0] OP_CALL_LOW    = 5'h11;
    localparam logic [4:0] OP_JUMP_LOW    = 5'h01;
    localparam logic [7:0] OP_ADD_IMM     = 8'h24;
    localparam logic [7:0] OP_ADD_DIR     = 8'h25;
    localparam logic [6:0] OP_ADD_IND     = 7'h13;
    localparam logic [4:0] OP_ADD_REG     = 5'h05;
    localparam logic [7:0] OP_ADC_IMM     = 8'h34;
    localparam logic [7:0] OP_ADC_DIR     = 8'h35;
    localparam logic [6:0] OP_ADC_IND     = 7'h1b;
    localparam logic [4:0] OP_ADC_REG     = 5'h07;
    // Field positions
    localparam int PAGE_HI_MSB  = 7;
    localparam int PAGE_HI_LSB  = 5;
    localparam int PAGE_BITS    = 11;
    // Byte lengths and stack step
    localparam logic [15:0] LEN_ONE     = 16'h0001;
    localparam logic [15:0] LEN_TWO     = 16'h0002;
    localparam logic [7:0]  SP_STEP     = 8'h01;
    // Reset values and data RAM depth
    localparam logic [15:0] PC_RST      = 16'h0000;
    localparam logic [7:0]  SP_RST      = 8'h07;
    localparam logic [7:0]  BYTE_ZERO   = 8'h00;
    localparam logic [1:0]  BANK_RST    = 2'h0;
    localparam int          RAM_DEPTH   = 256;
    // Execution states, one-hot
    typedef enum logic [5:0] {
        ST_FETCH = 6'h01,
        ST_OPND  = 6'h02,
        ST_PTR   = 6'h04,
        ST_DATA  = 6'h08,
        ST_PUSHL = 6'h10,
        ST_PUSHH = 6'h20
    } acjae_state_t;
endpackage

// file: acjae_ram_if.sv
`timescale 1ns/10ps
// Port of the internal data memory, shared by the core and the RAM
interface acjae_ram_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic [7:0] rdata;
    modport core (output addr, output wdata, output we, input rdata);
    modport mem  (input addr, input wdata, input we, output rdata);
endinterface

// file: acjae_ram.sv
`timescale 1ns/10ps
// Internal data RAM; read data registered, one cycle after the address
module acjae_ram
(
    input  wire logic clk,
    acjae_ram_if.mem  bus
);
    logic [7:0] mem_r [acjae_pkg::RAM_DEPTH];
    logic [7:0] rdata_r;

    // Read first, so a read of the same address sees old data
    always_ff @(posedge clk)
    begin
        if (bus.we)
            mem_r[bus.addr] <= bus.wdata;
        rdata_r <= mem_r[bus.addr];
    end
    assign bus.rdata = rdata_r;
endmodule

// file: acjae_core.sv
`timescale 1ns/10ps
// How it works
// - call opcode holds page bits 10..8 in bits 7..5 over 10001, low byte next.
// - call adds 2 to PC, then pushes low then high return byte with pre-increment.
// - call then replaces PC bits 0..10 with page address; 2 bytes, 4 cycles.
// - call target keeps upper PC bits of the already incremented counter.
// - jump opcode holds page bits 10..8 in bits 7..5 over 00001, low byte next.
// - jump adds 2 then replaces low 11 PC bits, no push; 2 bytes, 2 cycles.
// - jump target stays in the page of the following instruction.
// - opcode 24 plus immediate byte adds it into the accumulator.
// - opcode 0010011r adds RAM byte pointed by work register 0 or 1.
// - register add sums work register 0..7 into the accumulator.
// - opcode 25 plus direct address adds that RAM byte into the accumulator.
// - opcode 34 adds carry plus immediate byte; carry from three-term sum.
// - opcode 0011011r adds carry plus indirect RAM byte, updates carry.
// - register add-with-carry adds carry at bit 0 plus work register.
// - opcode 35 adds carry plus direct RAM byte, updates carry.
// - every add instruction advances PC by its own byte length; jump and call load the page target.
// - page address operand is an 11-bit code address within a 2K page.
module acjae_core
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  code_byte,
    input  wire logic [1:0]  bank_sel,
    output logic      [15:0] program_counter,
    output logic      [7:0]  accumulator,
    output logic      [7:0]  stack_pointer,
    output logic             carry_flag,
    output logic             aux_carry_flag,
    output logic             overflow_flag,
    output logic             parity_flag,
    output logic             instr_done
);
    acjae_ram_if ram ();

    acjae_ram u_ram
    (
        .clk (clk),
        .bus (ram.mem)
    );

    acjae_pkg::acjae_state_t state_r, state_nxt;
    logic [15:0] pc_r, pc_nxt;
    logic [7:0]  acc_r, acc_nxt;
    logic [7:0]  sp_r, sp_nxt;
    logic [7:0]  op_r, op_nxt;
    logic [7:0]  opnd_r, opnd_nxt;
    logic        cy_r, cy_nxt;
    logic        ac_r, ac_nxt;
    logic        ov_r, ov_nxt;
    logic        p_r, p_nxt;
    logic        done_r, done_nxt;
    logic [1:0]  bank_r;
    logic [7:0]  ram_addr;
    logic [7:0]  ram_wdata;
    logic        ram_we;

    // Decode helpers
    logic is_call;
    logic is_jump;
    logic is_imm;
    logic is_dir;
    logic is_ind;
    logic is_reg;
    logic use_cy;
    logic [7:0] reg_addr;

    // Decoded from the held opcode, so the operand cycle sees a stable class
    assign is_call = (op_r[4:0] == acjae_pkg::OP_CALL_LOW);
    assign is_jump = (op_r[4:0] == acjae_pkg::OP_JUMP_LOW);

    // Work register address: bank from selector, register from low bits
    assign reg_addr = {3'h0, bank_r, code_byte[2:0]};

    // Sum of accumulator, operand and optional carry
    function automatic logic [11:0] add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic ci);
        logic [4:0] lo;
        logic [3:0] hi;
        logic [7:0] s;
        logic       c7;
        logic       c8;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        hi = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
        c8 = (a[7] & b[7]) | (a[7] & hi[3]) | (b[7] & hi[3]);
        c7 = hi[3];
        s  = {a[7] ^ b[7] ^ hi[3], hi[2:0], lo[3:0]};
        add8 = {c8, lo[4], c8 ^ c7, ^s, s};
    endfunction

    logic [11:0] sum;

    // Bank is sampled from same-clock logic, so no synchroniser
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            bank_r <= acjae_pkg::BANK_RST;
        else
            bank_r <= bank_sel;
    end

    // Next-state and datapath computation
    always_comb
    begin
        state_nxt = state_r;
        pc_nxt    = pc_r;
        acc_nxt   = acc_r;
        sp_nxt    = sp_r;
        op_nxt    = op_r;
        opnd_nxt  = opnd_r;
        cy_nxt    = cy_r;
        ac_nxt    = ac_r;
        ov_nxt    = ov_r;
        p_nxt     = p_r;
        done_nxt  = 1'b0;
        ram_addr  = acjae_pkg::BYTE_ZERO;
        ram_wdata = acjae_pkg::BYTE_ZERO;
        ram_we    = 1'b0;
        is_imm    = 1'b0;
        is_dir    = 1'b0;
        is_ind    = 1'b0;
        is_reg    = 1'b0;
        use_cy    = 1'b0;
        sum       = add8(acc_r, ram.rdata, 1'b0);
        case (state_r)
            acjae_pkg::ST_FETCH:
            begin
                op_nxt = code_byte;
                // Step past the opcode so program memory shows the operand next
                pc_nxt = pc_r + acjae_pkg::LEN_ONE;
                is_ind = (code_byte[7:1] == acjae_pkg::OP_ADD_IND)
                       | (code_byte[7:1] == acjae_pkg::OP_ADC_IND);
                is_reg = (code_byte[7:3] == acjae_pkg::OP_ADD_REG)
                       | (code_byte[7:3] == acjae_pkg::OP_ADC_REG);
                if (is_ind)
                begin
                    ram_addr  = reg_addr & ~8'h06; // Register 0 or 1 of the bank
                    state_nxt = acjae_pkg::ST_PTR;
                end
                else if (is_reg)
                begin
                    ram_addr  = reg_addr;
                    state_nxt = acjae_pkg::ST_DATA;
                end
                else
                    state_nxt = acjae_pkg::ST_OPND;
            end
            acjae_pkg::ST_OPND:
            begin
                opnd_nxt = code_byte;
                is_imm   = (op_r == acjae_pkg::OP_ADD_IMM) | (op_r == acjae_pkg::OP_ADC_IMM);
                is_dir   = (op_r == acjae_pkg::OP_ADD_DIR) | (op_r == acjae_pkg::OP_ADC_DIR);
                use_cy   = (op_r == acjae_pkg::OP_ADC_IMM);
                sum      = add8(acc_r, code_byte, use_cy & cy_r);
                pc_nxt   = pc_r + acjae_pkg::LEN_ONE;
                if (is_imm)
                begin
                    {cy_nxt, ac_nxt, ov_nxt, p_nxt, acc_nxt} = sum;
                    done_nxt  = 1'b1;
                    state_nxt = acjae_pkg::ST_FETCH;
                end
                else if (is_dir)
                begin
                    ram_addr  = code_byte;
                    state_nxt = acjae_pkg::ST_DATA;
                end
                else if (is_call)
                begin
                    sp_nxt    = sp_r + acjae_pkg::SP_STEP;
                    state_nxt = acjae_pkg::ST_PUSHL;
                end
                else if (is_jump)
                begin
                    // Upper bits from the counter already past both bytes
                    pc_nxt    = {pc_nxt[15:acjae_pkg::PAGE_BITS],
                                 op_r[acjae_pkg::PAGE_HI_MSB:acjae_pkg::PAGE_HI_LSB],
                                 code_byte};
                    done_nxt  = 1'b1;
                    state_nxt = acjae_pkg::ST_FETCH;
                end
                else
                begin
                    // Undecoded opcodes are skipped as two-byte no-ops
                    done_nxt  = 1'b1;
                    state_nxt = acjae_pkg::ST_FETCH;
                end
            end
            acjae_pkg::ST_PTR:
            begin
                ram_addr  = ram.rdata; // Pointer value fetched last cycle
                state_nxt = acjae_pkg::ST_DATA;
            end
            acjae_pkg::ST_DATA:
            begin
                use_cy = op_r[4]; // Carry-in forms share opcode bit 4
                sum    = add8(acc_r, ram.rdata, use_cy & cy_r);
                {cy_nxt, ac_nxt, ov_nxt, p_nxt, acc_nxt} = sum;
                done_nxt  = 1'b1;
                state_nxt = acjae_pkg::ST_FETCH;
            end
            acjae_pkg::ST_PUSHL:
            begin
                ram_addr  = sp_r;
                ram_wdata = pc_r[7:0];
                ram_we    = 1'b1;
                sp_nxt    = sp_r + acjae_pkg::SP_STEP;
                state_nxt = acjae_pkg::ST_PUSHH;
            end
            acjae_pkg::ST_PUSHH:
            begin
                ram_addr  = sp_r;
                ram_wdata = pc_r[15:8];
                ram_we    = 1'b1;
                // High return byte is pushed in the same cycle as the page replaces low bits
                pc_nxt    = {pc_r[15:acjae_pkg::PAGE_BITS],
                             op_r[acjae_pkg::PAGE_HI_MSB:acjae_pkg::PAGE_HI_LSB],
                             opnd_r};
                done_nxt  = 1'b1;
                state_nxt = acjae_pkg::ST_FETCH;
            end
            default:
                state_nxt = acjae_pkg::ST_FETCH;
        endcase
    end

    assign ram.addr  = ram_addr;
    assign ram.wdata = ram_wdata;
    assign ram.we    = ram_we;

    // Architectural state registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_r <= acjae_pkg::ST_FETCH;
            pc_r    <= acjae_pkg::PC_RST;
            acc_r   <= acjae_pkg::BYTE_ZERO;
            sp_r    <= acjae_pkg::SP_RST;
            op_r    <= acjae_pkg::BYTE_ZERO;
            opnd_r  <= acjae_pkg::BYTE_ZERO;
            cy_r    <= 1'b0;
            ac_r    <= 1'b0;
            ov_r    <= 1'b0;
            p_r     <= 1'b0;
            done_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            pc_r    <= pc_nxt;
            acc_r   <= acc_nxt;
            sp_r    <= sp_nxt;
            op_r    <= op_nxt;
            opnd_r  <= opnd_nxt;
            cy_r    <= cy_nxt;
            ac_r    <= ac_nxt;
            ov_r    <= ov_nxt;
            p_r     <= p_nxt;
            done_r  <= done_nxt;
        end
    end

    assign program_counter = pc_r;
    assign accumulator     = acc_r;
    assign stack_pointer   = sp_r;
    assign carry_flag      = cy_r;
    assign aux_carry_flag  = ac_r;
    assign overflow_flag   = ov_r;
    assign parity_flag     = p_r;
    assign instr_done      = done_r;

    // Checks beside the logic
    a_call_sp_step: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_OPND && op_r[4:0] == acjae_pkg::OP_CALL_LOW
        |=> sp_r == $past(sp_r) + acjae_pkg::SP_STEP ##1 sp_r == $past(sp_r, 2) + 8'h02)
        else $error("call did not step stack pointer twice");
    a_call_push_low: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_PUSHL |-> ram_we && ram_wdata == pc_r[7:0])
        else $error("low return byte not pushed first");
    a_call_target: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_PUSHH |=> pc_r[10:0] == {$past(op_r[7:5]), $past(opnd_r)})
        else $error("call target wrong");
    a_call_upper: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_PUSHH |=> pc_r[15:11] == $past(pc_r[15:11]))
        else $error("call upper bits changed");
    a_jump_target: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_OPND && op_r[4:0] == acjae_pkg::OP_JUMP_LOW
        |=> pc_r[10:0] == {$past(op_r[7:5]), $past(code_byte)} && sp_r == $past(sp_r))
        else $error("jump target wrong");
    a_jump_page: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_OPND && op_r[4:0] == acjae_pkg::OP_JUMP_LOW
        |=> pc_r[15:11] == $past(pc_r + acjae_pkg::LEN_ONE) >> acjae_pkg::PAGE_BITS)
        else $error("jump left page");
    a_add_imm: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_OPND && op_r == acjae_pkg::OP_ADD_IMM
        |=> acc_r == 8'($past(acc_r) + $past(code_byte)) && instr_done)
        else $error("immediate add wrong");
    a_adc_imm: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_OPND && op_r == acjae_pkg::OP_ADC_IMM
        |=> {cy_r, acc_r} == 9'($past(acc_r) + $past(code_byte) + $past(cy_r)))
        else $error("immediate add with carry wrong");
    a_one_byte_pc: assert property (@(posedge clk) disable iff (sys_rst)
        state_r == acjae_pkg::ST_FETCH && state_nxt != acjae_pkg::ST_OPND
        |=> pc_r == $past(pc_r) + acjae_pkg::LEN_ONE)
        else $error("one-byte length not applied");
    a_parity_flag: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(done_r) && op_r[7:5] == 3'h1 && op_r[3:2] != 2'h0 |-> p_r == ^acc_r)
        else $error("parity mismatch");

    c_call: cover property (@(posedge clk) state_r == acjae_pkg::ST_PUSHH);
    c_jump: cover property (@(posedge clk)
        state_r == acjae_pkg::ST_OPND && op_r[4:0] == acjae_pkg::OP_JUMP_LOW);
    c_indirect: cover property (@(posedge clk) state_r == acjae_pkg::ST_PTR);
    c_carry_out: cover property (@(posedge clk) $rose(cy_r));
endmodule

// file: acjae_prog_mem.sv
`timescale 1ns/10ps
// Program memory model: answers the counter with its byte in the same cycle
module acjae_prog_mem
(
    input  wire logic [15:0] program_counter,
    output logic      [7:0]  code_byte
);
    // Only the low 8K is modelled; the bench keeps its program below that
    logic [7:0] mem [0:8191] = '{default: 8'h00};

    // Combinational read, as the core samples the byte on the same edge
    assign code_byte = mem[program_counter[12:0]];
endmodule

// file: acjae_tb_top.sv
`timescale 1ns/10ps
module acjae_tb_top;
    logic        clk;
    logic        sys_rst;
    logic [1:0]  bank_sel;
    logic [7:0]  code_byte;
    logic [15:0] program_counter;
    logic [7:0]  accumulator;
    logic [7:0]  stack_pointer;
    logic        carry_flag;
    logic        aux_carry_flag;
    logic        overflow_flag;
    logic        parity_flag;
    logic        instr_done;
    int          failures;
    int          compares;
    logic [7:0]  exp_acc;
    logic [3:0]  exp_flags;
    // Arithmetic program: opcode, operand byte, and the data value it should add
    logic [7:0]  ar_op  [0:14] = '{8'h24, 8'h24, 8'h3a, 8'h24, 8'h34, 8'h34, 8'h25, 8'h35,
                                   8'h26, 8'h27, 8'h24, 8'h36, 8'h37, 8'h2b, 8'h3d};
    logic [7:0]  ar_arg [0:14] = '{8'hf0, 8'h20, 8'h00, 8'h7f, 8'hff, 8'h0e, 8'h0d, 8'h0a,
                                   8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  ar_val [0:14] = '{8'hf0, 8'h20, 8'h07, 8'h7f, 8'hff, 8'h0e, 8'h10, 8'h07,
                                   8'h08, 8'h08, 8'hf8, 8'h08, 8'h08, 8'h09, 8'h10};

    acjae_core i_acjae_core (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .code_byte       (code_byte),
        .bank_sel        (bank_sel),
        .program_counter (program_counter),
        .accumulator     (accumulator),
        .stack_pointer   (stack_pointer),
        .carry_flag      (carry_flag),
        .aux_carry_flag  (aux_carry_flag),
        .overflow_flag   (overflow_flag),
        .parity_flag     (parity_flag),
        .instr_done      (instr_done)
    );

    acjae_prog_mem i_acjae_prog_mem (
        .program_counter (program_counter),
        .code_byte       (code_byte)
    );

    // 10 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Two-byte forms are the immediate and direct ones of both add families
    function automatic logic [15:0] op_len(input logic [7:0] op);
        return (op[7:1] == 7'h12 || op[7:1] == 7'h1a) ? 16'h0002 : 16'h0001;
    endfunction

    // Reference sum: {carry, aux carry, overflow, parity, sum}
    function automatic logic [11:0] ref_add(input logic [7:0] a, input logic [7:0] b,
                                            input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] m;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        m = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, ci};
        return {s[8], h[4], m[7] ^ s[8], ^s[7:0], s[7:0]};
    endfunction

    // Bounded wait for the completion pulse, then compare the architectural state
    task automatic step(input logic [15:0] pc_e, input logic [7:0] sp_e);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end while (instr_done !== 1'b1 && n < 20);
        check("instr_done", {15'h0000, instr_done}, 16'h0001);
        check("program_counter", program_counter, pc_e);
        check("stack_pointer", {8'h00, stack_pointer}, {8'h00, sp_e});
        check("accumulator", {8'h00, accumulator}, {8'h00, exp_acc});
        check("flags", {12'h000, carry_flag, aux_carry_flag, overflow_flag, parity_flag},
              {12'h000, exp_flags});
    endtask

    task automatic check_idle_state;
        exp_acc = 8'h00;
        exp_flags = 4'h0;
        check("reset pc", program_counter, 16'h0000);
        check("reset sp", {8'h00, stack_pointer}, 16'h0007);
        check("reset acc", {8'h00, accumulator}, 16'h0000);
        check("reset flags", {12'h000, carry_flag, aux_carry_flag, overflow_flag, parity_flag},
              16'h0000);
    endtask

    // Program image; calls push return bytes that later serve as work registers
    task automatic load_prog;
        logic [15:0] a;
        i_acjae_prog_mem.mem[13'h0000] = 8'he1;
        i_acjae_prog_mem.mem[13'h0001] = 8'hfe;
        i_acjae_prog_mem.mem[13'h07fe] = 8'h01;
        i_acjae_prog_mem.mem[13'h07ff] = 8'h06;
        i_acjae_prog_mem.mem[13'h0806] = 8'h31;
        i_acjae_prog_mem.mem[13'h0807] = 8'h05;
        i_acjae_prog_mem.mem[13'h0905] = 8'hf1;
        i_acjae_prog_mem.mem[13'h0906] = 8'hfe;
        i_acjae_prog_mem.mem[13'h0ffe] = 8'h71;
        i_acjae_prog_mem.mem[13'h0fff] = 8'h00;
        a = 16'h1300;
        for (int i = 0; i < 15; i++)
        begin
            i_acjae_prog_mem.mem[a[12:0]] = ar_op[i];
            i_acjae_prog_mem.mem[a[12:0] + 13'h0001] = ar_arg[i];
            a = a + op_len(ar_op[i]);
        end
    endtask

    // Jumps: within page, then across the 2K boundary carried by the increment
    task automatic page_jumps;
        step(16'h07fe, 8'h07);
        step(16'h0806, 8'h07);
    endtask

    // Calls: push low then high return byte, target keeps the incremented upper bits
    task automatic page_calls;
        step(16'h0905, 8'h09);
        step(16'h0ffe, 8'h0b);
        step(16'h1300, 8'h0d);
    endtask

    // Every add form; RAM operands come from the bytes the calls pushed into bank 1
    task automatic arith_forms;
        logic [15:0] pc;
        logic [11:0] r;
        pc = 16'h1300;
        for (int i = 0; i < 15; i++)
        begin
            r = ref_add(exp_acc, ar_val[i], ar_op[i][4] & exp_flags[3]);
            exp_acc = r[7:0];
            exp_flags = r[11:8];
            pc = pc + op_len(ar_op[i]);
            step(pc, 8'h0d);
        end
    endtask

    // Reset in mid-run, then the first jump again from the reset vector
    task automatic mid_reset;
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check_idle_state();
        @(posedge clk);
        sys_rst <= 1'b0;
        step(16'h07fe, 8'h07);
    endtask

    initial
    begin
        failures = 0;
        compares = 0;
        sys_rst <= 1'b1;
        bank_sel <= 2'h1;
        load_prog();
        // Released on the fourth edge, so exactly four edges see reset
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check_idle_state();
        page_jumps();
        page_calls();
        arith_forms();
        mid_reset();
        end_sim();
    end

    // Watchdog: the run needs a few hundred cycles at most
    initial
    begin
        #(3000 * 100);
        failures++;
        end_sim();
    end
endmodule
